/* src/nas_pkg.sv */
// package for the nt line activation sequencer: codes, states, timing
// assumes a 125 MHz clock and a command/indication code exchange of 4 bits
package nas_pkg;

    // command codes from the controller
    localparam logic [3:0] CMD_NOP        = 4'h0;
    localparam logic [3:0] CMD_POWER_ON   = 4'h1;
    localparam logic [3:0] CMD_ACTIVATE   = 4'h2;
    localparam logic [3:0] CMD_FULL_CLEAR = 4'h3;
    localparam logic [3:0] CMD_ERROR_REQ  = 4'h4;
    localparam logic [3:0] CMD_DEACTIVATE = 4'h5;
    localparam logic [3:0] CMD_POWER_DOWN = 4'h6;
    localparam logic [3:0] CMD_LINE_ONLY  = 4'h7;

    // indication codes towards the controller
    localparam logic [3:0] IND_NONE       = 4'h0;
    localparam logic [3:0] IND_WAKE_TONE  = 4'h1;
    localparam logic [3:0] IND_POWERED_UP = 4'h2;
    localparam logic [3:0] IND_ACT_PEND   = 4'h3;
    localparam logic [3:0] IND_LINE_ONLY  = 4'h4;
    localparam logic [3:0] IND_FULL_ACT   = 4'h5;
    localparam logic [3:0] IND_ERROR      = 4'h6;
    localparam logic [3:0] IND_DEACT_PEND = 4'h7;
    localparam logic [3:0] IND_TERM_DROP  = 4'h8;

    // internal hardware timeout on the way to sync, in microseconds
    localparam int SYNC_TIMEOUT_US = 1000;
    localparam int CLOCK_MHZ       = 125;
    localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_US * CLOCK_MHZ;
    localparam int TMR_W           = 20;

    typedef enum logic [7:0] {
        ST_POWERED_DOWN = 8'h01,
        ST_FULL_RESET   = 8'h02,
        ST_LINE_SYNCED  = 8'h04,
        ST_LINE_ONLY    = 8'h08,
        ST_FULL_ACTIVE  = 8'h10,
        ST_ERROR_WAIT   = 8'h20,
        ST_ACT_WAIT     = 8'h40,
        ST_DEACT_DONE   = 8'h80
    } nas_state_t;

    // received line condition, synchronised
    typedef struct packed {
        logic wake_tone;
        logic frame_sync;
        logic superframe_sync;
        logic signal_ok;
        logic live_link;
        logic line_only_hold;
        logic shutdown;
    } nas_line_t;

    typedef struct packed {
        nas_state_t          state;
        logic [TMR_W-1:0]    timer;
        logic [3:0]          ind;
        logic                ind_stb;
        logic                live_link_tx;
        logic                coef_clear;
        logic                core_reset;
        logic                powered;
        logic                err_is_live;
        nas_line_t           l1;
        nas_line_t           l2;
        // one stage past the synchroniser, for edge detection
        nas_line_t           l3;
    } nas_regs_t;

endpackage

/* src/nas_sequencer.sv */
// activation/deactivation sequencer for a subscriber-side line transceiver
// assumes line status pins are asynchronous; commands come as one-cycle strobes
`timescale 1ns/1ps

// What this block does
// - wake tone seen gives wake tone indication
// - power-up and activate lead to full reset
// - sync reached reports pending or line-only
// - no sync gives hardware timeout or error
// - line synced: full activation or error
// - full clear resets and clears coefficients
// - error request sends live bit cleared upstream
// - line-only hold cleared reports terminal drop
// - shutdown bit cleared reports deactivation pending
// - active faults or live bit cleared give error
// - line-only activate request yields activation pending
// - line-only hold set reports activation pending
// - reset routine makes next start cold
// - deactivate resets but keeps coefficients
// - power-down enters power-down state and clears powered, no reset
// - after live-bit error, recover or warm reset
// - after signal loss error, cold reset
module nas_sequencer (
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic       cmd_stb_i,
    input  wire logic [3:0] cmd_code_i,
    input  wire logic       wake_tone_i,
    input  wire logic       frame_sync_i,
    input  wire logic       superframe_sync_i,
    input  wire logic       signal_ok_i,
    input  wire logic       live_link_i,
    input  wire logic       line_only_hold_i,
    input  wire logic       shutdown_i,
    output logic [3:0]      ind_code_o,
    output logic            ind_stb_o,
    output logic            live_link_tx_o,
    output logic            coef_clear_o,
    output logic            core_reset_o,
    output logic            powered_o,
    output logic [7:0]      state_o
);

    nas_pkg::nas_regs_t r_ff;
    nas_pkg::nas_regs_t nxt_r;

    localparam logic [nas_pkg::TMR_W-1:0] TMO =
        nas_pkg::TMR_W'(nas_pkg::SYNC_TIMEOUT_CYC);

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic [3:0]     new_ind;
        logic           fault;
        logic           synced;
        logic           act_cmd;
        logic           lo_cmd;
        nas_pkg::nas_line_t ln;
        new_ind = nas_pkg::IND_NONE;
        nxt_r   = r_ff;
        ln      = r_ff.l2;
        // two-flop synchroniser for line status
        nxt_r.l1 = '{wake_tone_i, frame_sync_i, superframe_sync_i, signal_ok_i,
                     live_link_i, line_only_hold_i, shutdown_i};
        nxt_r.l2 = r_ff.l1;
        nxt_r.l3 = r_ff.l2;
        nxt_r.ind_stb    = 1'b0;
        nxt_r.coef_clear = 1'b0;
        nxt_r.core_reset = 1'b0;
        fault   = !ln.signal_ok || !ln.frame_sync || !ln.superframe_sync;
        synced  = ln.frame_sync && ln.superframe_sync;
        act_cmd = cmd_stb_i && cmd_code_i == nas_pkg::CMD_ACTIVATE;
        lo_cmd  = cmd_stb_i && cmd_code_i == nas_pkg::CMD_LINE_ONLY;
        if (r_ff.timer != '0) begin
            nxt_r.timer = r_ff.timer - 1'b1;
        end

        unique case (r_ff.state)
            nas_pkg::ST_POWERED_DOWN: begin
                if (ln.wake_tone && !r_ff.l3.wake_tone) begin
                    new_ind = nas_pkg::IND_WAKE_TONE;
                end
                if (cmd_stb_i && cmd_code_i == nas_pkg::CMD_POWER_ON) begin
                    nxt_r.powered = 1'b1;
                end
                if ((act_cmd || lo_cmd) && r_ff.powered) begin
                    nxt_r.state = nas_pkg::ST_FULL_RESET;
                    nxt_r.timer = TMO;
                    nxt_r.err_is_live = lo_cmd;
                    new_ind = nas_pkg::IND_POWERED_UP;
                end
            end
            nas_pkg::ST_FULL_RESET: begin
                // err_is_live holds the requested flavour here
                if (synced) begin
                    nxt_r.state = r_ff.err_is_live ? nas_pkg::ST_LINE_ONLY
                                                   : nas_pkg::ST_LINE_SYNCED;
                    new_ind = r_ff.err_is_live ? nas_pkg::IND_LINE_ONLY
                                               : nas_pkg::IND_ACT_PEND;
                    nxt_r.timer = TMO;
                    nxt_r.err_is_live = 1'b0;
                end else if (r_ff.timer == '0) begin
                    new_ind = nas_pkg::IND_ERROR;
                    nxt_r.state = nas_pkg::ST_POWERED_DOWN;
                end
            end
            nas_pkg::ST_LINE_SYNCED: begin
                if (fault || r_ff.timer == '0) begin
                    new_ind = nas_pkg::IND_ERROR;
                    nxt_r.state = nas_pkg::ST_ERROR_WAIT;
                    nxt_r.err_is_live = 1'b0;
                end else if (ln.live_link) begin
                    new_ind = nas_pkg::IND_FULL_ACT;
                    nxt_r.state = nas_pkg::ST_FULL_ACTIVE;
                end
            end
            nas_pkg::ST_FULL_ACTIVE: begin
                if (cmd_stb_i && cmd_code_i == nas_pkg::CMD_ERROR_REQ) begin
                    nxt_r.live_link_tx = 1'b0;
                    nxt_r.timer = TMO;
                end else if (!ln.shutdown) begin
                    new_ind = nas_pkg::IND_DEACT_PEND;
                    nxt_r.state = nas_pkg::ST_DEACT_DONE;
                end else if (!ln.line_only_hold) begin
                    new_ind = nas_pkg::IND_TERM_DROP;
                    nxt_r.state = nas_pkg::ST_LINE_ONLY;
                end else if (fault || !ln.live_link) begin
                    new_ind = nas_pkg::IND_ERROR;
                    nxt_r.state = nas_pkg::ST_ERROR_WAIT;
                    nxt_r.err_is_live = !fault;
                end else if (!r_ff.live_link_tx && r_ff.timer == '0) begin
                    new_ind = nas_pkg::IND_ERROR;
                    nxt_r.state = nas_pkg::ST_ERROR_WAIT;
                    nxt_r.err_is_live = 1'b0;
                end
            end
            nas_pkg::ST_LINE_ONLY: begin
                if (act_cmd) begin
                    nxt_r.state = nas_pkg::ST_ACT_WAIT;
                    nxt_r.timer = TMO;
                end else if (!ln.shutdown) begin
                    new_ind = nas_pkg::IND_DEACT_PEND;
                    nxt_r.state = nas_pkg::ST_DEACT_DONE;
                end else if (fault) begin
                    new_ind = nas_pkg::IND_ERROR;
                    nxt_r.state = nas_pkg::ST_ERROR_WAIT;
                    nxt_r.err_is_live = 1'b0;
                end else if (ln.line_only_hold && !r_ff.l3.line_only_hold) begin
                    new_ind = nas_pkg::IND_ACT_PEND;
                    nxt_r.state = nas_pkg::ST_LINE_SYNCED;
                    nxt_r.timer = TMO;
                end
            end
            nas_pkg::ST_ACT_WAIT: begin
                if (fault || r_ff.timer == '0) begin
                    new_ind = nas_pkg::IND_ERROR;
                    nxt_r.state = nas_pkg::ST_ERROR_WAIT;
                    nxt_r.err_is_live = 1'b0;
                end else begin
                    new_ind = nas_pkg::IND_ACT_PEND;
                    nxt_r.state = nas_pkg::ST_LINE_SYNCED;
                    nxt_r.timer = TMO;
                end
            end
            nas_pkg::ST_ERROR_WAIT: begin
                if (r_ff.err_is_live && !fault && ln.live_link) begin
                    new_ind = nas_pkg::IND_FULL_ACT;
                    nxt_r.state = nas_pkg::ST_FULL_ACTIVE;
                    nxt_r.live_link_tx = 1'b1;
                end else if (r_ff.err_is_live && !ln.shutdown) begin
                    new_ind = nas_pkg::IND_DEACT_PEND;
                    nxt_r.state = nas_pkg::ST_DEACT_DONE;
                end
            end
            nas_pkg::ST_DEACT_DONE: begin
                // warm reset: core restarts, coefficients kept
                nxt_r.core_reset = 1'b1;
                nxt_r.state = nas_pkg::ST_POWERED_DOWN;
                nxt_r.live_link_tx = 1'b1;
                nxt_r.err_is_live = 1'b0;
            end
            default: begin
                nxt_r.state = nas_pkg::ST_POWERED_DOWN;
            end
        endcase

        // controller routines act from any state
        if (cmd_stb_i && cmd_code_i == nas_pkg::CMD_FULL_CLEAR) begin
            nxt_r.state = nas_pkg::ST_POWERED_DOWN;
            nxt_r.core_reset = 1'b1;
            nxt_r.coef_clear = 1'b1;
            nxt_r.live_link_tx = 1'b1;
            nxt_r.err_is_live = 1'b0;
            new_ind = nas_pkg::IND_NONE;
        end else if (cmd_stb_i && cmd_code_i == nas_pkg::CMD_DEACTIVATE) begin
            nxt_r.state = nas_pkg::ST_DEACT_DONE;
            new_ind = nas_pkg::IND_NONE;
        end else if (cmd_stb_i && cmd_code_i == nas_pkg::CMD_POWER_DOWN) begin
            nxt_r.state = nas_pkg::ST_POWERED_DOWN;
            nxt_r.powered = 1'b0;
            new_ind = nas_pkg::IND_NONE;
        end else if (r_ff.state == nas_pkg::ST_ERROR_WAIT && !r_ff.err_is_live) begin
            // signal loss error: cold reset
            nxt_r.state = nas_pkg::ST_POWERED_DOWN;
            nxt_r.core_reset = 1'b1;
            nxt_r.coef_clear = 1'b1;
            nxt_r.live_link_tx = 1'b1;
        end

        if (new_ind != nas_pkg::IND_NONE) begin
            nxt_r.ind = new_ind;
            nxt_r.ind_stb = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_ff <= '{state: nas_pkg::ST_POWERED_DOWN, live_link_tx: 1'b1,
                      l1: '{default: 1'b0}, l2: '{default: 1'b0},
                      l3: '{default: 1'b0},
                      default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign ind_code_o     = r_ff.ind;
    assign ind_stb_o      = r_ff.ind_stb;
    assign live_link_tx_o = r_ff.live_link_tx;
    assign coef_clear_o   = r_ff.coef_clear;
    assign core_reset_o   = r_ff.core_reset;
    assign powered_o      = r_ff.powered;
    assign state_o        = r_ff.state;

endmodule

/* test/nas_monitor.sv */
// checker on the sequencer ports: activation, resets, line faults
// assumes nas_pkg codes; bound to every sequencer instance below
`timescale 1ns/1ps
module nas_monitor (
    input wire logic       clock_i,
    input wire logic       nrst_i,
    input wire logic       cmd_stb_i,
    input wire logic [3:0] cmd_code_i,
    input wire logic       wake_tone_i,
    input wire logic       frame_sync_i,
    input wire logic       superframe_sync_i,
    input wire logic       signal_ok_i,
    input wire logic [3:0] ind_code_o,
    input wire logic       ind_stb_o,
    input wire logic       live_link_tx_o,
    input wire logic       coef_clear_o,
    input wire logic       core_reset_o,
    input wire logic       powered_o,
    input wire logic [7:0] state_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire logic [3:0] cmd = cmd_stb_i ? cmd_code_i : nas_pkg::CMD_NOP;
    sequence s_synced;
        (state_o == 8'h04 && ind_code_o == nas_pkg::IND_ACT_PEND) ||
        (state_o == 8'h08 && ind_code_o == nas_pkg::IND_LINE_ONLY);
    endsequence
    sequence s_cold;
        (ind_stb_o && ind_code_o == nas_pkg::IND_ERROR) ##[1:2] (core_reset_o && coef_clear_o);
    endsequence
    ////////////////////
    AST_WAKE: assert property ($rose(wake_tone_i) && state_o == 8'h01 |-> ##[2:4]
        (ind_stb_o && ind_code_o == nas_pkg::IND_WAKE_TONE)) else $error("wake tone missed");
    AST_ACT: assert property (cmd == nas_pkg::CMD_ACTIVATE && powered_o && state_o == 8'h01
        |=> state_o == 8'h02 && ind_stb_o && ind_code_o == nas_pkg::IND_POWERED_UP)
        else $error("activate did not reach full reset");
    AST_SYNC: assert property ((state_o == 8'h02 && frame_sync_i && superframe_sync_i
        && signal_ok_i)[*3] |-> ##[0:3] s_synced) else $error("sync not reported");
    AST_FULL: assert property (state_o == 8'h10 && $past(state_o) != 8'h10
        |-> ind_stb_o && ind_code_o == nas_pkg::IND_FULL_ACT) else $error("silent activation");
    AST_CLEAR: assert property (cmd == nas_pkg::CMD_FULL_CLEAR
        |-> ##[1:2] (core_reset_o && coef_clear_o)) else $error("full clear incomplete");
    AST_DEACT: assert property (cmd == nas_pkg::CMD_DEACTIVATE
        |-> ##[1:2] (core_reset_o && !coef_clear_o)) else $error("deactivate wrong");
    AST_PDOWN: assert property (cmd == nas_pkg::CMD_POWER_DOWN
        |-> ##[1:2] (state_o == 8'h01 && !coef_clear_o)) else $error("power down wrong");
    AST_ERRREQ: assert property (cmd == nas_pkg::CMD_ERROR_REQ && state_o == 8'h10
        |-> ##[1:2] !live_link_tx_o) else $error("live bit not cleared");
    AST_LOSS: assert property ((state_o == 8'h10 && !signal_ok_i)[*2]
        |-> ##[0:3] s_cold) else $error("signal loss not handled");
endmodule

bind nas_sequencer nas_monitor i_mon (.clock_i(clock_i), .nrst_i(nrst_i),
    .cmd_stb_i(cmd_stb_i), .cmd_code_i(cmd_code_i), .wake_tone_i(wake_tone_i),
    .frame_sync_i(frame_sync_i), .superframe_sync_i(superframe_sync_i),
    .signal_ok_i(signal_ok_i), .ind_code_o(ind_code_o), .ind_stb_o(ind_stb_o),
    .live_link_tx_o(live_link_tx_o), .coef_clear_o(coef_clear_o),
    .core_reset_o(core_reset_o), .powered_o(powered_o), .state_o(state_o));

/* test/nas_ctl_model.sv */
// controller model: sends command codes, runs the activation guard timer
// assumes commands are one-cycle strobes taken at the rising edge
`timescale 1ns/1ps
module nas_ctl_model #(parameter int SETTLE = 4, parameter int GUARD = 400) (
    input  wire logic       clock_i,
    input  wire logic       ind_stb_i,
    input  wire logic [3:0] ind_code_i,
    output logic            cmd_stb_o = 1'b0,
    output logic [3:0]      cmd_code_o = 4'h0,
    output logic            fatal_o = 1'b0
);
    int guard = 0;
    task automatic send(input logic [3:0] code);
        @(negedge clock_i);
        cmd_stb_o = 1'b1;
        cmd_code_o = code;
        @(negedge clock_i);
        cmd_stb_o = 1'b0;
        cmd_code_o = ~code;
    endtask
    task automatic activate();
        send(nas_pkg::CMD_POWER_ON);
        repeat (SETTLE) @(negedge clock_i);
        send(nas_pkg::CMD_ACTIVATE);
        guard = GUARD;
    endtask
    always @(posedge clock_i) begin
        if (ind_stb_i === 1'b1 && ind_code_i === nas_pkg::IND_FULL_ACT)
            guard <= 0;
        else if (guard == 1)
            fatal_o <= 1'b1;
        if (guard > 0)
            guard <= guard - 1;
    end
endmodule

/* test/testbench.sv */
// self-checking bench: line levels, commands via the controller model
// assumes nas_pkg codes and the one-hot state encoding
`timescale 1ns/1ps
module testbench;
    logic        clock_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        wake = 1'b0, fsync = 1'b0, sfsync = 1'b0, sig_ok = 1'b0;
    logic        live = 1'b0, hold = 1'b1, shut = 1'b1;
    logic        cmd_stb, ind_stb, live_tx, coef, core, powered, fatal;
    logic [3:0]  cmd_code, ind_code;
    logic [7:0]  state;
    logic [3:0]  exp_q[$];
    logic [16:0] rnd = 17'h17794;
    int          failures = 0, comparisons = 0, n_core = 0, n_coef = 0, c0, f0;
    always #4 clock_i = ~clock_i;
    nas_sequencer i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .cmd_stb_i(cmd_stb),
        .cmd_code_i(cmd_code), .wake_tone_i(wake), .frame_sync_i(fsync),
        .superframe_sync_i(sfsync), .signal_ok_i(sig_ok), .live_link_i(live),
        .line_only_hold_i(hold), .shutdown_i(shut), .ind_code_o(ind_code),
        .ind_stb_o(ind_stb), .live_link_tx_o(live_tx), .coef_clear_o(coef),
        .core_reset_o(core), .powered_o(powered), .state_o(state));
    nas_ctl_model i_ctl (.clock_i(clock_i), .ind_stb_i(ind_stb), .ind_code_i(ind_code),
        .cmd_stb_o(cmd_stb), .cmd_code_o(cmd_code), .fatal_o(fatal));
    ////////////////////
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic chk(input bit ok, input string what);
        comparisons++;
        if (!ok) begin
            failures++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask
    task automatic final_report();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // each strobe must match the oldest expected indication
    always @(negedge clock_i) begin
        if (nrst_i && ind_stb === 1'b1) begin
            chk(exp_q.size() > 0 && ind_code === exp_q[0], "indication code");
            if (exp_q.size() > 0)
                void'(exp_q.pop_front());
        end
        n_core += int'(core === 1'b1);
        n_coef += int'(coef === 1'b1);
    end
    task automatic settle();
        for (int i = 0; i < 60 && exp_q.size() > 0; i++) @(negedge clock_i);
        if (exp_q.size() > 0) begin
            failures++;
            $display("MISMATCH at %0t: indication missing", $time);
            final_report();
        end
    endtask
    task automatic pulse_cmd(input logic [3:0] code, input int dc, input int df);
        // let pulses of the previous step be counted first
        repeat (2) @(negedge clock_i);
        c0 = n_core;
        f0 = n_coef;
        i_ctl.send(code);
        repeat (3) @(negedge clock_i);
        chk(n_core - c0 == dc && n_coef - f0 == df, "reset pulses");
    endtask
    task automatic lines(input logic v);
        @(negedge clock_i);
        {fsync, sfsync, sig_ok, live} = {4{v}};
    endtask
    task automatic bring_up();
        exp_q.push_back(nas_pkg::IND_POWERED_UP);
        i_ctl.activate();
        settle();
        rnd = lfsr(rnd);
        repeat (rnd[2:0]) @(negedge clock_i);
        exp_q.push_back(nas_pkg::IND_ACT_PEND);
        exp_q.push_back(nas_pkg::IND_FULL_ACT);
        lines(1'b1);
        settle();
        chk(state === 8'h10, "not fully active");
    endtask
    ////////////////////
    initial begin
        repeat (3) @(negedge clock_i);
        nrst_i = 1'b1;
        chk(state === 8'h01 && ind_code === 4'h0 && live_tx === 1'b1, "reset values");
        i_ctl.send(nas_pkg::CMD_ACTIVATE);
        rnd = lfsr(rnd);
        i_ctl.send(4'h8 | rnd[3:0]);
        repeat (4) @(negedge clock_i);
        chk(state === 8'h01 && powered === 1'b0, "unpowered activate taken");
        exp_q.push_back(nas_pkg::IND_WAKE_TONE);
        wake = 1'b1;
        settle();
        wake = 1'b0;
        bring_up();
        exp_q.push_back(nas_pkg::IND_TERM_DROP);
        hold = 1'b0;
        settle();
        chk(state === 8'h08, "not line-only");
        exp_q.push_back(nas_pkg::IND_ACT_PEND);
        exp_q.push_back(nas_pkg::IND_FULL_ACT);
        hold = 1'b1;
        settle();
        rnd = lfsr(rnd);
        i_ctl.send(4'h8 | rnd[3:0]);
        exp_q.push_back(nas_pkg::IND_ERROR);
        live = 1'b0;
        settle();
        exp_q.push_back(nas_pkg::IND_FULL_ACT);
        live = 1'b1;
        settle();
        exp_q.push_back(nas_pkg::IND_DEACT_PEND);
        shut = 1'b0;
        settle();
        pulse_cmd(nas_pkg::CMD_DEACTIVATE, 1, 0);
        pulse_cmd(nas_pkg::CMD_POWER_DOWN, 0, 0);
        chk(state === 8'h01, "not powered down");
        lines(1'b0);
        shut = 1'b1;
        bring_up();
        i_ctl.send(nas_pkg::CMD_ERROR_REQ);
        @(negedge clock_i);
        chk(live_tx === 1'b0, "live bit still sent");
        exp_q.push_back(nas_pkg::IND_DEACT_PEND);
        shut = 1'b0;
        settle();
        pulse_cmd(nas_pkg::CMD_FULL_CLEAR, 1, 1);
        pulse_cmd(nas_pkg::CMD_POWER_DOWN, 0, 0);
        lines(1'b0);
        shut = 1'b1;
        bring_up();
        c0 = n_core;
        f0 = n_coef;
        exp_q.push_back(nas_pkg::IND_ERROR);
        sig_ok = 1'b0;
        settle();
        repeat (3) @(negedge clock_i);
        chk(n_core - c0 == 1 && n_coef - f0 == 1, "no cold reset");
        lines(1'b0);
        pulse_cmd(nas_pkg::CMD_POWER_DOWN, 0, 0);
        exp_q.push_back(nas_pkg::IND_POWERED_UP);
        i_ctl.activate();
        for (int i = 0; i < 600 && fatal !== 1'b1; i++) @(negedge clock_i);
        chk(fatal === 1'b1, "guard did not expire");
        final_report();
    end
endmodule
